// ---- bench/iapfc_flash_model.sv ----
/*
  Flash array model: 16K words, erase to zero, word write and read.
  Driven by the fl_* pins of the control block.
*/
`timescale 1ns/1ps
`default_nettype none
module iapfc_flash_model (
  input  wire logic        pclk,     // Clock
  input  wire logic        fl_erase, // Erase strobe
  input  wire logic        fl_write, // Write strobe
  input  wire logic        fl_read,  // Read strobe
  input  wire logic [13:0] fl_addr,  // Word address
  input  wire logic [15:0] fl_wdata, // Write data
  output logic      [15:0] fl_rdata  // Read data
);
  logic [15:0] mem [16384];
  logic [15:0] last_r;
  // Known contents so untouched words stand out
  initial
  begin
    for (int i = 0; i < 16384; i++)
      mem[i] = 16'hA500 ^ 16'(i);
    last_r = 16'h0000;
  end
  // Array updates; erased words read zero
  always @(posedge pclk)
  begin
    if (fl_erase)
      mem[fl_addr] <= 16'h0000; // Blank value
    if (fl_write)
      mem[fl_addr] <= fl_wdata;
    if (fl_read)
      last_r <= mem[fl_addr];
  end
  // Released data lines show the inverse of the last word
  assign fl_rdata = fl_read ? mem[fl_addr] : ~last_r;
endmodule : iapfc_flash_model
`default_nettype wire

// ---- bench/iapfc_monitor.sv ----
/*
  Checker for the flash program control block, bound to iapfc_top.
  Assumes one clock, async active-low reset and zero-wait APB.
*/
`timescale 1ns/1ps
`default_nettype none
module iapfc_monitor #(
  parameter int ERASE_SHORT = 24, // Erase cycles, select 0
  parameter int WRITE_SHORT = 20, // Write cycles, select 0
  parameter int ERASE_LONG  = 36, // Erase cycles, select 1
  parameter int WRITE_LONG  = 30, // Write cycles, select 1
  parameter int UNLOCK_LEN  = 16  // Unlock window cycles
) (
  input wire logic        pclk,      // Clock
  input wire logic        presetn,   // Reset, active low
  input wire logic        psel,      // APB select
  input wire logic        penable,   // APB enable
  input wire logic        pwrite,    // APB direction
  input wire logic [7:0]  paddr,     // APB address
  input wire logic [31:0] pwdata,    // APB write data
  input wire logic [31:0] prdata,    // APB read data
  input wire logic        cpu_stall, // CPU stall
  input wire logic        chip_rst,  // Chip reset
  input wire logic        fl_erase,  // Erase strobe
  input wire logic        fl_write,  // Write strobe
  input wire logic        fl_read,   // Read strobe
  input wire logic [13:0] fl_addr,   // Array address
  input wire logic [31:0] fl_wmask   // Tagged words
);
  logic        wr_acc;
  logic        rd_acc;
  logic [11:0] stall_cnt_r;
  logic [11:0] stall_cnt_nxt;
  // Access-phase decodes
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  // Length of the current stall
  assign stall_cnt_nxt = cpu_stall ? stall_cnt_r + 12'h001 : 12'h000;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      stall_cnt_r <= 12'h000;
    else
      stall_cnt_r <= stall_cnt_nxt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_key;
    wr_acc && paddr == iapfc_pkg::OFF_RST_PATTERN && pwdata[7:0] == iapfc_pkg::CHIP_RST_KEY;
  endsequence
  sequence s_pulse;
    chip_rst [*8];
  endsequence
  sequence s_hi_wr;
    wr_acc && paddr == iapfc_pkg::OFF_DATA1_HIGH && !cpu_stall;
  endsequence
  property p_rst_go;
    s_key |-> ##[1:4] s_pulse;
  endproperty
  property p_rst_quiet;
    wr_acc && paddr == iapfc_pkg::OFF_RST_PATTERN && pwdata[7:0] != 8'h55 && !chip_rst
      |=> !chip_rst [*4];
  endproperty
  property p_erase_tag;
    fl_erase |-> fl_wmask[fl_addr[4:0]] && cpu_stall;
  endproperty
  property p_op_stall;
    fl_write || fl_read |-> cpu_stall;
  endproperty
  property p_tm_zero;
    rd_acc && paddr == iapfc_pkg::OFF_TIMING_BUF |-> prdata[31:2] == 30'h0;
  endproperty
  property p_rd_locked;
    wr_acc && paddr == iapfc_pkg::OFF_OP_CTRL && pwdata[2:0] == 3'h1 && !cpu_stall
      |=> (!cpu_stall && !fl_read) [*4];
  endproperty
  property p_addr_inc;
    logic [13:0] a;
    (s_hi_wr and fl_addr[4:0] != 5'h1F, a = fl_addr) |-> ##2 fl_addr == a + 14'h0001;
  endproperty
  property p_addr_hold;
    logic [13:0] a;
    (s_hi_wr and fl_addr[4:0] == 5'h1F, a = fl_addr) |-> ##2 fl_addr == a;
  endproperty
  property p_stall_max;
    stall_cnt_r <= ERASE_LONG + 8;
  endproperty
  a_rst_go: assert property (p_rst_go) else $error("no reset after key");
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset on bad key");
  a_erase_tag: assert property (p_erase_tag) else $error("untagged erase");
  a_op_stall: assert property (p_op_stall) else $error("op without stall");
  a_tm_zero: assert property (p_tm_zero) else $error("upper bits set");
  a_rd_locked: assert property (p_rd_locked) else $error("read not allowed");
  a_addr_inc: assert property (p_addr_inc) else $error("no increment");
  a_addr_hold: assert property (p_addr_hold) else $error("passed page end");
  a_stall_max: assert property (p_stall_max) else $error("stall too long");
endmodule : iapfc_monitor

bind iapfc_top iapfc_monitor #(
  .ERASE_SHORT(ERASE_SHORT), .WRITE_SHORT(WRITE_SHORT), .ERASE_LONG(ERASE_LONG),
  .WRITE_LONG(WRITE_LONG), .UNLOCK_LEN(UNLOCK_LEN)
) i_iapfc_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .cpu_stall, .chip_rst, .fl_erase, .fl_write, .fl_read, .fl_addr, .fl_wmask);
`default_nettype wire

// ---- bench/tb_iap_flash_program_control.sv ----
/*
  Testbench for the flash program control block: APB master, flash model, checker.
  Assumes shortened erase/write counts and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_iap_flash_program_control;
  localparam int ES = 40, WS = 36, EL = 48, WL = 44, UL = 40;
  localparam logic [7:0] OP = iapfc_pkg::OFF_OP_CTRL, TM = iapfc_pkg::OFF_TIMING_BUF;
  localparam logic [7:0] DL = iapfc_pkg::OFF_DATA1_LOW, DH = iapfc_pkg::OFF_DATA1_HIGH;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, unl;
  logic        cpu_stall, chip_rst, fl_erase, fl_write, fl_read;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, fl_wmask;
  logic [13:0] fl_addr;
  logic [15:0] fl_wdata, fl_rdata, v;
  int          num_errors, checked, n;

  iapfc_top #(.ERASE_SHORT(ES), .WRITE_SHORT(WS), .ERASE_LONG(EL), .WRITE_LONG(WL),
    .UNLOCK_LEN(UL)) i_iapfc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cpu_stall, .chip_rst, .fl_erase, .fl_write,
    .fl_read, .fl_addr, .fl_wdata, .fl_wmask, .fl_rdata);
  iapfc_flash_model i_iapfc_flash_model (.pclk, .fl_erase, .fl_write, .fl_read, .fl_addr,
    .fl_wdata, .fl_rdata);

  // Clock, stable before any op
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic close_out;
    $display("Counts: %0d compared, %0d bad", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic hang;
    num_errors++;
    close_out();
  endtask : hang
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 20 && pready !== 1'b1; k++)
      @(posedge pclk);
    if (k == 20)
      hang();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Waits out one operation, returning its stall length
  task automatic run_op(output int c);
    int k;
    for (k = 0; k < 4 && cpu_stall !== 1'b1; k++)
      @(posedge pclk);
    for (c = 0; c < 500 && cpu_stall === 1'b1; c++)
      @(posedge pclk);
    if (c == 500)
      hang();
  endtask : run_op
  task automatic set_addr(input logic [13:0] a);
    apb(iapfc_pkg::OFF_ADDR_LOW, 1'b1, {24'h0, a[7:0]});
    apb(iapfc_pkg::OFF_ADDR_HIGH, 1'b1, {26'h0, a[13:8]});
  endtask : set_addr
  // Reads one array word through the read operation
  task automatic do_rd(input logic [13:0] a);
    logic [7:0] lo;
    set_addr(a);
    apb(OP, 1'b1, {24'h0, unl, 7'h33});
    run_op(n);
    apb(DL, 1'b0, 32'h0);
    lo = rd[7:0];
    apb(DH, 1'b0, 32'h0);
    v = {rd[7:0], lo};
  endtask : do_rd
  task automatic t_regs;
    apb(OP, 1'b0, 32'h0);
    chk(rd, 32'h0);                 // Control clear after reset
    apb(TM, 1'b1, 32'hFC);
    apb(TM, 1'b0, 32'h0);
    chk(rd, 32'h0);                 // Upper timing bits stay zero
    apb(OP, 1'b1, 32'h80);
    apb(OP, 1'b0, 32'h0);
    chk(rd[7], 1'b0);               // Software set of flag ignored
    apb(8'h38, 1'b0, 32'h0);
    chk(err, 1'b1);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_unlock(input logic good);
    apb(OP, 1'b1, 32'h68);
    apb(iapfc_pkg::OFF_DATA2_LOW, 1'b1, 32'(iapfc_pkg::PAT_D2L)); // Pattern order
    apb(iapfc_pkg::OFF_DATA3_LOW, 1'b1, 32'(iapfc_pkg::PAT_D3L));
    apb(iapfc_pkg::OFF_DATA4_LOW, 1'b1, 32'(iapfc_pkg::PAT_D4L));
    apb(iapfc_pkg::OFF_DATA2_HIGH, 1'b1, 32'(iapfc_pkg::PAT_D2H));
    apb(iapfc_pkg::OFF_DATA3_HIGH, 1'b1, 32'(iapfc_pkg::PAT_D3H));
    apb(iapfc_pkg::OFF_DATA4_HIGH, 1'b1, good ? 32'h40 : 32'h41); // Written in time
    apb(OP, 1'b0, 32'h0);
    chk(rd[6:3], 4'hD);             // Unlock mode with timer running
    chk(rd[7], good);               // Flag only on full match
    repeat (UL) @(posedge pclk);
    apb(OP, 1'b0, 32'h0);
    chk(rd[3], 1'b0);               // Trigger cleared at expiry
    chk(rd[7], good);               // Flag held after timer expiry
    unl = good;
    $display("t_unlock %0d done", good);
  endtask : t_unlock
  task automatic t_erase;
    set_addr(14'h0020);
    apb(DH, 1'b1, 32'h0);
    apb(DH, 1'b1, 32'h0);
    set_addr(14'h003F);
    apb(DH, 1'b1, 32'h0);
    apb(DH, 1'b1, 32'h0);
    apb(iapfc_pkg::OFF_TAG_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h8000_0003);         // Tags stop at last word
    apb(OP, 1'b1, 32'h94);
    run_op(n);
    chk(n >= ES - 3 && n <= ES + 2, 1'b1); // Short erase time
    apb(OP, 1'b0, 32'h0);
    chk(rd[2], 1'b0);               // Go bit self-clears
    do_rd(14'h0021);
    chk(v, 16'h0000);               // Tagged word erased
    do_rd(14'h0022);
    chk(v, 16'hA522);               // Untagged word kept
    do_rd(14'h003F);
    chk(v, 16'h0000);               // Last word erased
    apb(OP, 1'b0, 32'h0);
    chk(rd[0], 1'b0);               // Read go self-clears
    $display("t_erase done");
  endtask : t_erase
  task automatic t_write;
    int k;
    apb(TM, 1'b1, 32'h3);
    for (k = 0; k < 8; k++)
    begin
      apb(TM, 1'b0, 32'h0);
      if (rd[0] === 1'b0)
        break;
    end
    chk(rd, 32'h2);                 // Clear done, select kept
    apb(iapfc_pkg::OFF_TAG_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0);                 // Buffer tags cleared
    set_addr(14'h0024);
    apb(DL, 1'b1, 32'h34);
    apb(DH, 1'b1, 32'h12);
    apb(OP, 1'b1, 32'h84);
    run_op(n);
    chk(n >= WL - 3 && n <= WL + 2, 1'b1); // Long write time
    do_rd(14'h0024);
    chk(v, 16'h1234);               // Full word written
    $display("t_write done");
  endtask : t_write
  task automatic t_lock;
    logic [2:0] rsv [4] = '{3'h2, 3'h4, 3'h5, 3'h7};
    foreach (rsv[i])
    begin
      apb(OP, 1'b1, {24'h0, 1'b1, rsv[i], 4'h4});
      run_op(n);
      chk(n, 0);                    // Reserved mode starts nothing
    end
    apb(OP, 1'b1, 32'h0);
    unl = 1'b0;
    apb(OP, 1'b1, 32'h14);
    run_op(n);
    chk(n, 0);                      // Erase refused when locked
    apb(OP, 1'b1, 32'h31);
    run_op(n);
    chk(n, 0);                      // Read refused without allow
    $display("t_lock done");
  endtask : t_lock
  task automatic t_chip(input logic [7:0] key, input int exp);
    int k;
    apb(iapfc_pkg::OFF_RST_PATTERN, 1'b1, {24'h0, key});
    n = 0;
    for (k = 0; k < 24; k++)
    begin
      @(posedge pclk);
      if (chip_rst === 1'b1)
        n++;
    end
    chk(n, exp);                    // Reset only on key
    $display("t_chip %h done", key);
  endtask : t_chip
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    unl = 1'b0;
    num_errors = 0;
    checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_unlock(1'b0);
    t_unlock(1'b1);
    t_erase();
    t_write();
    t_lock();
    t_chip(8'h54, 0);
    t_chip(8'h55, 16);
    close_out();
  end
endmodule : tb_iap_flash_program_control
`default_nettype wire

// ---- rtl/iapfc_pkg.sv ----
/*
  Package for the flash program control block: register offsets, field positions,
  reset values, mode codes, unlock pattern and timing counts.
  Assumes a 40 MHz pclk and a 32-bit APB with word-aligned registers.
*/
package iapfc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_ADDR_LOW    = 8'h00;
  localparam logic [7:0] OFF_ADDR_HIGH   = 8'h04;
  localparam logic [7:0] OFF_DATA1_LOW   = 8'h08;
  localparam logic [7:0] OFF_DATA1_HIGH  = 8'h0C;
  localparam logic [7:0] OFF_DATA2_LOW   = 8'h10;
  localparam logic [7:0] OFF_DATA2_HIGH  = 8'h14;
  localparam logic [7:0] OFF_DATA3_LOW   = 8'h18;
  localparam logic [7:0] OFF_DATA3_HIGH  = 8'h1C;
  localparam logic [7:0] OFF_DATA4_LOW   = 8'h20;
  localparam logic [7:0] OFF_DATA4_HIGH  = 8'h24;
  localparam logic [7:0] OFF_OP_CTRL     = 8'h28;
  localparam logic [7:0] OFF_RST_PATTERN = 8'h2C;
  localparam logic [7:0] OFF_TIMING_BUF  = 8'h30;
  localparam logic [7:0] OFF_TAG_STATUS  = 8'h34;
  // Operation control field positions
  localparam int BIT_UNLOCKED = 7;
  localparam int BIT_MODE_HI  = 6;
  localparam int BIT_MODE_LO  = 4;
  localparam int BIT_TRIGGER  = 3;
  localparam int BIT_PROG_GO  = 2;
  localparam int BIT_RD_ALLOW = 1;
  localparam int BIT_RD_GO    = 0;
  // Timing and buffer control field positions
  localparam int BIT_TIME_SEL = 1;
  localparam int BIT_BUF_CLR  = 0;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Mode codes
  typedef enum logic [2:0] {
    MODE_WRITE  = 3'h0,
    MODE_ERASE  = 3'h1,
    MODE_READ   = 3'h3,
    MODE_UNLOCK = 3'h6
  } iapfc_mode_t;
  // Chip reset trigger value
  localparam logic [7:0] CHIP_RST_KEY = 8'h55;
  // Unlock pattern, data2..4 low then data2..4 high
  localparam logic [7:0] PAT_D2L = 8'h00;
  localparam logic [7:0] PAT_D3L = 8'h0D;
  localparam logic [7:0] PAT_D4L = 8'hC3;
  localparam logic [7:0] PAT_D2H = 8'h04;
  localparam logic [7:0] PAT_D3H = 8'h09;
  localparam logic [7:0] PAT_D4H = 8'h40;
  // Page geometry
  localparam int PAGE_WORDS   = 32;
  localparam int WORD_AW      = 5;
  localparam logic [4:0] LAST_WORD = 5'h1F;
  // Timing, in ns and derived cycles (all times round up to whole cycles)
  localparam int CLK_NS          = 25;
  localparam int ERASE_SHORT_NS  = 3200000;
  localparam int WRITE_SHORT_NS  = 2200000;
  localparam int ERASE_LONG_NS   = 3700000;
  localparam int WRITE_LONG_NS   = 3000000;
  localparam int ERASE_SHORT_CYC = (ERASE_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_SHORT_CYC = (WRITE_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_LONG_CYC  = (ERASE_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_LONG_CYC  = (WRITE_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int UNLOCK_CYC      = 1024;
  localparam int READ_CYC        = 4;
  localparam int CHIP_RST_CYC    = 16;
endpackage : iapfc_pkg

// ---- rtl/iapfc_top.sv ----
/*
  Flash program control: APB registers, unlock sequence, page erase tagging,
  32-word write buffer, timed erase/write/read and chip reset pattern.
  Assumes the flash array sits outside on the fl_* pins and the CPU honours cpu_stall.
*/
`timescale 1ns/1ps
`default_nettype none

module iapfc_top #(
  parameter int ERASE_SHORT = iapfc_pkg::ERASE_SHORT_CYC, // Erase cycles, select 0
  parameter int WRITE_SHORT = iapfc_pkg::WRITE_SHORT_CYC, // Write cycles, select 0
  parameter int ERASE_LONG  = iapfc_pkg::ERASE_LONG_CYC,  // Erase cycles, select 1
  parameter int WRITE_LONG  = iapfc_pkg::WRITE_LONG_CYC,  // Write cycles, select 1
  parameter int UNLOCK_LEN  = iapfc_pkg::UNLOCK_CYC       // Unlock window cycles
) (
  input  wire logic        pclk,          // APB clock, 40 MHz
  input  wire logic        presetn,       // Async reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB direction
  input  wire logic [7:0]  paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic [31:0]      prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error
  output logic             cpu_stall,     // Stall CPU during operation
  output logic             chip_rst,      // Whole-chip reset pulse
  output logic             fl_erase,      // Erase strobe to array
  output logic             fl_write,      // Write strobe to array
  output logic             fl_read,       // Read strobe to array
  output logic [13:0]      fl_addr,       // Array address
  output logic [15:0]      fl_wdata,      // Array write data
  output logic [31:0]      fl_wmask,      // Words of the page in the operation
  input  wire logic [15:0] fl_rdata       // Array read data
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PROG  = 2'b01,
    ST_READ  = 2'b10,
    ST_CLEAR = 2'b11
  } iapfc_state_t;

  // APB decode
  logic wr_en;
  logic rd_en;
  logic known;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign known   = (paddr <= iapfc_pkg::OFF_TAG_STATUS) && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !known;

  // Registers
  logic [7:0]  addr_lo_r;
  logic [5:0]  addr_hi_r;
  logic [7:0]  d1l_r, d1h_r, d2l_r, d2h_r, d3l_r, d3h_r, d4l_r, d4h_r;
  logic        unlocked_r;
  logic [2:0]  mode_r;
  logic        trigger_r;
  logic        prog_go_r;
  logic        rd_allow_r;
  logic        rd_go_r;
  logic [7:0]  rst_pat_r;
  logic        time_sel_r;
  logic        buf_clr_r;
  logic [31:0] tag_r;
  logic [15:0] wbuf_r [iapfc_pkg::PAGE_WORDS];
  logic [15:0] rd_word_r;
  iapfc_state_t state_r;
  logic [22:0] op_cnt_r;
  logic [15:0] unl_cnt_r;
  logic [4:0]  chip_cnt_r;
  logic [4:0]  walk_r;

  logic wr_addr_lo, wr_addr_hi, wr_d1h, wr_ctrl, wr_tb;
  assign wr_addr_lo = wr_en && known && paddr == iapfc_pkg::OFF_ADDR_LOW;
  assign wr_addr_hi = wr_en && known && paddr == iapfc_pkg::OFF_ADDR_HIGH;
  assign wr_d1h     = wr_en && known && paddr == iapfc_pkg::OFF_DATA1_HIGH;
  assign wr_ctrl    = wr_en && known && paddr == iapfc_pkg::OFF_OP_CTRL;
  assign wr_tb      = wr_en && known && paddr == iapfc_pkg::OFF_TIMING_BUF;

  logic busy;
  logic done_op;
  assign busy    = state_r != ST_IDLE;
  assign done_op = busy && op_cnt_r == 23'h000001;

  // Pattern match over all six bytes
  logic pat_ok;
  assign pat_ok = d2l_r == iapfc_pkg::PAT_D2L && d3l_r == iapfc_pkg::PAT_D3L &&
                  d4l_r == iapfc_pkg::PAT_D4L && d2h_r == iapfc_pkg::PAT_D2H &&
                  d3h_r == iapfc_pkg::PAT_D3H && d4h_r == iapfc_pkg::PAT_D4H;

  // Address pair, auto-increment stops at last word of page
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_lo_r <= iapfc_pkg::RST_BYTE;
      addr_hi_r <= 6'h00;
    end
    else if (wr_addr_lo)
      addr_lo_r <= pwdata[7:0];
    else if (wr_addr_hi)
      addr_hi_r <= pwdata[5:0];
    else if (wr_d1h && !busy && addr_lo_r[4:0] != iapfc_pkg::LAST_WORD)
      addr_lo_r <= addr_lo_r + 8'h01;
  end

  // Data registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      d1l_r <= iapfc_pkg::RST_BYTE;
      d1h_r <= iapfc_pkg::RST_BYTE;
      d2l_r <= iapfc_pkg::RST_BYTE;
      d2h_r <= iapfc_pkg::RST_BYTE;
      d3l_r <= iapfc_pkg::RST_BYTE;
      d3h_r <= iapfc_pkg::RST_BYTE;
      d4l_r <= iapfc_pkg::RST_BYTE;
      d4h_r <= iapfc_pkg::RST_BYTE;
    end
    else if (wr_en && known)
    begin
      case (paddr)
        iapfc_pkg::OFF_DATA1_LOW:  d1l_r <= pwdata[7:0];
        iapfc_pkg::OFF_DATA1_HIGH: d1h_r <= pwdata[7:0];
        iapfc_pkg::OFF_DATA2_LOW:  d2l_r <= pwdata[7:0];
        iapfc_pkg::OFF_DATA2_HIGH: d2h_r <= pwdata[7:0];
        iapfc_pkg::OFF_DATA3_LOW:  d3l_r <= pwdata[7:0];
        iapfc_pkg::OFF_DATA3_HIGH: d3h_r <= pwdata[7:0];
        iapfc_pkg::OFF_DATA4_LOW:  d4l_r <= pwdata[7:0];
        iapfc_pkg::OFF_DATA4_HIGH: d4h_r <= pwdata[7:0];
        default:                   d1l_r <= d1l_r;
      endcase
    end
    else if (state_r == ST_READ && done_op)
    begin
      d1l_r <= rd_word_r[7:0];
      d1h_r <= rd_word_r[15:8];
    end
  end

  // Write buffer and tags; loads only while unlocked and idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tag_r <= 32'h0000_0000;
      for (int i = 0; i < iapfc_pkg::PAGE_WORDS; i++)
        wbuf_r[i] <= 16'h0000;
    end
    else if ((state_r == ST_CLEAR && done_op) ||
             (state_r == ST_PROG && done_op && mode_r == iapfc_pkg::MODE_WRITE))
    begin
      tag_r <= 32'h0000_0000;
      for (int i = 0; i < iapfc_pkg::PAGE_WORDS; i++)
        wbuf_r[i] <= 16'h0000;
    end
    else if (wr_d1h && unlocked_r && !busy)
    begin
      wbuf_r[addr_lo_r[4:0]] <= {pwdata[7:0], d1l_r};
      tag_r[addr_lo_r[4:0]]  <= 1'b1;
    end
  end

  // Unlocked flag: set by hardware only, cleared by software zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      unlocked_r <= 1'b0;
    else if (trigger_r && mode_r == iapfc_pkg::MODE_UNLOCK && pat_ok)
      unlocked_r <= 1'b1;
    else if (wr_ctrl && !pwdata[iapfc_pkg::BIT_UNLOCKED])
      unlocked_r <= 1'b0;
  end

  // Unlock trigger and its timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trigger_r <= 1'b0;
      unl_cnt_r <= 16'h0000;
    end
    else if (trigger_r)
    begin
      if (unl_cnt_r == 16'h0001)
        trigger_r <= 1'b0;
      unl_cnt_r <= unl_cnt_r - 16'h0001;
    end
    else if (wr_ctrl && pwdata[iapfc_pkg::BIT_TRIGGER] &&
             pwdata[iapfc_pkg::BIT_MODE_HI:iapfc_pkg::BIT_MODE_LO] == iapfc_pkg::MODE_UNLOCK)
    begin
      trigger_r <= 1'b1;
      unl_cnt_r <= 16'(UNLOCK_LEN);
    end
  end

  // Mode, read allow and go bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r     <= 3'h0;
      rd_allow_r <= 1'b0;
      prog_go_r  <= 1'b0;
      rd_go_r    <= 1'b0;
    end
    else if (done_op && state_r == ST_PROG)
      prog_go_r <= 1'b0;
    else if (done_op && state_r == ST_READ)
      rd_go_r <= 1'b0;
    else if (wr_ctrl && !busy)
    begin
      mode_r     <= pwdata[iapfc_pkg::BIT_MODE_HI:iapfc_pkg::BIT_MODE_LO];
      rd_allow_r <= pwdata[iapfc_pkg::BIT_RD_ALLOW];
      // Erase/write only start from a valid mode while unlocked
      prog_go_r  <= pwdata[iapfc_pkg::BIT_PROG_GO] && unlocked_r &&
                    (pwdata[6:4] == iapfc_pkg::MODE_WRITE ||
                     pwdata[6:4] == iapfc_pkg::MODE_ERASE);
      rd_go_r    <= pwdata[iapfc_pkg::BIT_RD_GO] && pwdata[iapfc_pkg::BIT_RD_ALLOW] &&
                    pwdata[6:4] == iapfc_pkg::MODE_READ;
    end
  end

  // Timing select and buffer clear go
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      time_sel_r <= 1'b0;
      buf_clr_r  <= 1'b0;
    end
    else if (done_op && state_r == ST_CLEAR)
      buf_clr_r <= 1'b0;
    else if (wr_tb && !busy)
    begin
      time_sel_r <= pwdata[iapfc_pkg::BIT_TIME_SEL];
      buf_clr_r  <= pwdata[iapfc_pkg::BIT_BUF_CLR];
    end
  end

  // Operation sequencer and duration counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r  <= ST_IDLE;
      op_cnt_r <= 23'h000000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (prog_go_r)
          begin
            state_r <= ST_PROG;
            if (mode_r == iapfc_pkg::MODE_ERASE)
              op_cnt_r <= time_sel_r ? 23'(ERASE_LONG) : 23'(ERASE_SHORT);
            else
              op_cnt_r <= time_sel_r ? 23'(WRITE_LONG) : 23'(WRITE_SHORT);
          end
          else if (rd_go_r && rd_allow_r)
          begin
            state_r  <= ST_READ;
            op_cnt_r <= 23'(iapfc_pkg::READ_CYC);
          end
          else if (buf_clr_r)
          begin
            state_r  <= ST_CLEAR;
            op_cnt_r <= 23'h000001;
          end
        end
        default:
        begin
          op_cnt_r <= op_cnt_r - 23'h000001;
          if (done_op)
            state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Word walker for erase/write over the page
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      walk_r <= 5'h00;
    else if (state_r == ST_PROG)
      walk_r <= walk_r + 5'h01;
    else
      walk_r <= 5'h00;
  end

  // Flash array strobes and data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fl_erase  <= 1'b0;
      fl_write  <= 1'b0;
      fl_read   <= 1'b0;
      fl_addr   <= 14'h0000;
      fl_wdata  <= 16'h0000;
      fl_wmask  <= 32'h0000_0000;
      rd_word_r <= 16'h0000;
    end
    else
    begin
      fl_erase <= state_r == ST_PROG && mode_r == iapfc_pkg::MODE_ERASE &&
                  tag_r[walk_r];
      fl_write <= state_r == ST_PROG && mode_r == iapfc_pkg::MODE_WRITE && tag_r[walk_r];
      fl_read  <= state_r == ST_READ && rd_allow_r;
      fl_addr  <= state_r == ST_PROG ? {addr_hi_r, addr_lo_r[7:5], walk_r}
                                     : {addr_hi_r, addr_lo_r};
      fl_wdata <= wbuf_r[walk_r];
      fl_wmask <= tag_r;
      if (state_r == ST_READ)
        rd_word_r <= fl_rdata;
    end
  end

  // CPU stall while any array operation runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cpu_stall <= 1'b0;
    else
      cpu_stall <= (state_r == ST_IDLE && (prog_go_r || (rd_go_r && rd_allow_r))) ||
                   (state_r == ST_PROG || state_r == ST_READ);
  end

  // Chip reset pattern register and pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_pat_r  <= iapfc_pkg::RST_BYTE;
      chip_cnt_r <= 5'h00;
      chip_rst   <= 1'b0;
    end
    else
    begin
      if (wr_en && known && paddr == iapfc_pkg::OFF_RST_PATTERN)
        rst_pat_r <= pwdata[7:0];
      if (wr_en && known && paddr == iapfc_pkg::OFF_RST_PATTERN &&
          pwdata[7:0] == iapfc_pkg::CHIP_RST_KEY)
        chip_cnt_r <= 5'(iapfc_pkg::CHIP_RST_CYC);
      else if (chip_cnt_r != 5'h00)
        chip_cnt_r <= chip_cnt_r - 5'h01;
      chip_rst <= chip_cnt_r != 5'h00;
    end
  end

  // APB read mux
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        iapfc_pkg::OFF_ADDR_LOW:    prdata <= {24'h000000, addr_lo_r};
        iapfc_pkg::OFF_ADDR_HIGH:   prdata <= {26'h0000000, addr_hi_r};
        iapfc_pkg::OFF_DATA1_LOW:   prdata <= {24'h000000, d1l_r};
        iapfc_pkg::OFF_DATA1_HIGH:  prdata <= {24'h000000, d1h_r};
        iapfc_pkg::OFF_DATA2_LOW:   prdata <= {24'h000000, d2l_r};
        iapfc_pkg::OFF_DATA2_HIGH:  prdata <= {24'h000000, d2h_r};
        iapfc_pkg::OFF_DATA3_LOW:   prdata <= {24'h000000, d3l_r};
        iapfc_pkg::OFF_DATA3_HIGH:  prdata <= {24'h000000, d3h_r};
        iapfc_pkg::OFF_DATA4_LOW:   prdata <= {24'h000000, d4l_r};
        iapfc_pkg::OFF_DATA4_HIGH:  prdata <= {24'h000000, d4h_r};
        iapfc_pkg::OFF_OP_CTRL:     prdata <= {24'h000000, unlocked_r, mode_r, trigger_r,
                                               prog_go_r, rd_allow_r, rd_go_r};
        iapfc_pkg::OFF_RST_PATTERN: prdata <= {24'h000000, rst_pat_r};
        iapfc_pkg::OFF_TIMING_BUF:  prdata <= {30'h00000000, time_sel_r, buf_clr_r};
        iapfc_pkg::OFF_TAG_STATUS:  prdata <= tag_r;
        default:                    prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : iapfc_top
`default_nettype wire
